// file: include/etc_pkg.sv
// package for the e1 transmit clock mode detector
// assumes clk at 20 MHz; line and master clocks are asynchronous pins
package etc_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  // master clock periods the line clock may stay high before all-ones
  localparam int unsigned HIGH_MCLK_LIMIT = 16;
  // clk periods without a line clock edge before it counts as static
  localparam int unsigned TX_LINE_CLOCK_STATIC_NS  = 2000;
  localparam int unsigned TX_LINE_CLOCK_STATIC_CYC = (TX_LINE_CLOCK_STATIC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // clk periods without a master clock edge before it counts as static
  localparam int unsigned MCLK_STATIC_NS  = 2000;
  localparam int unsigned MCLK_STATIC_CYC = (MCLK_STATIC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [1:0]  SYNC_RESET      = 2'h0;
  localparam logic [7:0]  CNT_RESET       = 8'h00;
  localparam logic [4:0]  HCNT_RESET      = 5'h00;

  typedef enum logic [1:0] {
    ETC_NORMAL,
    ETC_TRISTATE,
    ETC_ALL_ONES,
    ETC_SHAPER_OFF
  } etc_mode_t;

  typedef enum logic [1:0] {
    ETC_SYM_SPACE,
    ETC_SYM_POS,
    ETC_SYM_NEG
  } etc_sym_t;

  function automatic etc_sym_t etc_decode(input logic p, input logic n);
    if (p && !n) begin
      return ETC_SYM_POS;
    end else if (n && !p) begin
      return ETC_SYM_NEG;
    end
    return ETC_SYM_SPACE;
  endfunction
endpackage

// file: design/etc_tx_clock_mode.sv
// one channel of e1 transmit clock input logic: samples pulse inputs and
// decodes the static state of the line clock against the master clock.
// assumes all pin inputs are asynchronous to clk and slow against it.
//
// Functional notes
// [RULE1] in hardware mode sample pulse inputs on each line clock falling edge
// [RULE2] line clock held low: drivers go high-impedance low power
// [RULE3] line clock high over 16 master cycles with master running: all ones
// [RULE4] line clock high and master clock static: pulse shaper disabled
// [RULE5] host mode: all-ones selected by a control input, not by clock level
// [RULE6] far side keeps some transmit input toggling while shaper is off
// [RULE7] far side may instead hold a pulse input, clock or enable low
// [RULE8] all-ones pattern timed from the master clock
// [RULE9] far side keeps the master clock frequency stable
// [RULE10] pulse inputs active high; both high is a space
// [RULE11] line clock toggling again leaves all-ones; every edge restarts count
`timescale 1ns/1ps
`default_nettype none
module etc_tx_clock_mode
  import etc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic host_mode,
  input  wire logic host_all_ones,
  input  wire logic tx_line_clock,
  input  wire logic master_clock,
  input  wire logic tx_positive_pulse_in,
  input  wire logic tx_negative_pulse_in,
  output logic      line_pos_r,
  output logic      line_neg_r,
  output logic      drive_oe_r,
  output logic      shaper_en_r,
  output logic      tx_all_ones_mode,
  output etc_mode_t mode_r
);
  logic [1:0] tx_line_clock_s_r;
  logic [1:0] mclk_s_r;
  logic [1:0] pos_s_r;
  logic [1:0] neg_s_r;
  logic       tx_line_clock_d_r;
  logic       mclk_d_r;
  logic [7:0] tx_line_clock_idle_r;
  logic [7:0] mclk_idle_r;
  logic [4:0] high_cnt_r;
  logic       ones_phase_r;
  logic [7:0] tx_line_clock_idle_nxt;
  logic [7:0] mclk_idle_nxt;
  logic [4:0] high_cnt_nxt;
  etc_mode_t  mode_nxt;

  wire tx_line_clock_lvl    = tx_line_clock_s_r[1];
  wire mclk_lvl    = mclk_s_r[1];
  wire tx_line_clock_edge   = tx_line_clock_lvl ^ tx_line_clock_d_r;
  wire tx_line_clock_fall   = tx_line_clock_d_r & ~tx_line_clock_lvl;
  wire mclk_rise   = mclk_lvl & ~mclk_d_r;
  wire mclk_edge   = mclk_lvl ^ mclk_d_r;
  wire tx_line_clock_static = (tx_line_clock_idle_r >= 8'(TX_LINE_CLOCK_STATIC_CYC));
  wire mclk_static = (mclk_idle_r >= 8'(MCLK_STATIC_CYC));
  wire high_over   = (high_cnt_r > 5'(HIGH_MCLK_LIMIT));
  wire hw_ones     = !host_mode && tx_line_clock_lvl && high_over && !mclk_static;
  wire ones_sel    = host_mode ? host_all_ones : hw_ones; // [RULE5]
  etc_sym_t sym;
  assign sym = etc_decode(pos_s_r[1], neg_s_r[1]); // [RULE10]

  assign tx_line_clock_idle_nxt = tx_line_clock_edge ? CNT_RESET :
                         (tx_line_clock_static ? tx_line_clock_idle_r : tx_line_clock_idle_r + 8'h01);
  assign mclk_idle_nxt = mclk_edge ? CNT_RESET :
                         (mclk_static ? mclk_idle_r : mclk_idle_r + 8'h01);
  // restart on every line clock edge; count master clock rising edges while high
  assign high_cnt_nxt  = (tx_line_clock_edge || !tx_line_clock_lvl) ? HCNT_RESET : // [RULE11]
                         ((mclk_rise && !high_over) ? high_cnt_r + 5'h01 : high_cnt_r);

  always_comb begin
    mode_nxt = ETC_NORMAL;
    if (ones_sel) begin
      mode_nxt = ETC_ALL_ONES; // [RULE3]
    end else if (!host_mode && tx_line_clock_static && !tx_line_clock_lvl) begin
      mode_nxt = ETC_TRISTATE; // [RULE2]
    end else if (!host_mode && tx_line_clock_static && tx_line_clock_lvl && mclk_static) begin
      mode_nxt = ETC_SHAPER_OFF; // [RULE4]
    end
  end

  assign tx_all_ones_mode = (mode_r == ETC_ALL_ONES);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_line_clock_s_r <= SYNC_RESET;
      mclk_s_r <= SYNC_RESET;
      pos_s_r  <= SYNC_RESET;
      neg_s_r  <= SYNC_RESET;
      tx_line_clock_d_r <= 1'b0;
      mclk_d_r <= 1'b0;
    end else if (clk_en) begin
      tx_line_clock_s_r <= {tx_line_clock_s_r[0], tx_line_clock};
      mclk_s_r <= {mclk_s_r[0], master_clock};
      pos_s_r  <= {pos_s_r[0], tx_positive_pulse_in};
      neg_s_r  <= {neg_s_r[0], tx_negative_pulse_in};
      tx_line_clock_d_r <= tx_line_clock_lvl;
      mclk_d_r <= mclk_lvl;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_line_clock_idle_r <= CNT_RESET;
      mclk_idle_r <= CNT_RESET;
      high_cnt_r  <= HCNT_RESET;
      mode_r      <= ETC_NORMAL;
    end else if (clk_en) begin
      tx_line_clock_idle_r <= tx_line_clock_idle_nxt;
      mclk_idle_r <= mclk_idle_nxt;
      high_cnt_r  <= high_cnt_nxt;
      mode_r      <= mode_nxt;
    end
  end

  // line output: sampled data, all-ones alternating marks, or idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_pos_r   <= 1'b0;
      line_neg_r   <= 1'b0;
      ones_phase_r <= 1'b0;
      drive_oe_r   <= 1'b1;
      shaper_en_r  <= 1'b1;
    end else if (clk_en) begin
      drive_oe_r  <= (mode_nxt != ETC_TRISTATE);
      shaper_en_r <= (mode_nxt != ETC_SHAPER_OFF);
      if (mode_r == ETC_ALL_ONES) begin
        if (mclk_rise) begin // [RULE8]
          ones_phase_r <= ~ones_phase_r;
          line_pos_r   <= ~ones_phase_r;
          line_neg_r   <= ones_phase_r;
        end
      end else if (mode_r == ETC_NORMAL && tx_line_clock_fall) begin // [RULE1]
        line_pos_r <= (sym == ETC_SYM_POS);
        line_neg_r <= (sym == ETC_SYM_NEG);
      end else if (mode_r != ETC_NORMAL) begin
        line_pos_r <= 1'b0;
        line_neg_r <= 1'b0;
      end
    end
  end

  // named steps shared by the properties below
  sequence s_normal_fall;
    clk_en && mode_r == ETC_NORMAL && tx_line_clock_fall;
  endsequence

  sequence s_line_resumed;
    clk_en && !host_mode && tx_line_clock_edge ##1 clk_en && !host_mode;
  endsequence

  sequence s_parked_high_still;
    clk_en && !host_mode && tx_line_clock_static && tx_line_clock_lvl && mclk_static;
  endsequence

  a_fall_sample: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    s_normal_fall |=> line_pos_r == ($past(sym) == ETC_SYM_POS))
    else $error("positive pulse not captured on falling edge");

  a_both_space: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
    !(line_pos_r && line_neg_r))
    else $error("both line outputs high");

  a_low_tristate: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
    clk_en && mode_nxt == ETC_TRISTATE |=> !drive_oe_r)
    else $error("drivers not tristated with line clock low");

  a_shaper_off: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
    !shaper_en_r |-> !$past(host_mode) && $past(tx_line_clock_lvl))
    else $error("shaper off without line clock high");

  a_ones_cause: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
    $rose(tx_all_ones_mode) && !$past(host_mode) |-> $past(high_cnt_r) > 5'(HIGH_MCLK_LIMIT))
    else $error("all ones entered before 16 master cycles");

  a_host_ones: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
    clk_en && host_mode && host_all_ones |=> tx_all_ones_mode)
    else $error("host all-ones request ignored");

  a_edge_restart: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    clk_en && tx_line_clock_edge |=> high_cnt_r == HCNT_RESET)
    else $error("high count not restarted on line clock edge");

  a_ones_timing: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
    clk_en && tx_all_ones_mode && $past(tx_all_ones_mode) && !mclk_rise
    |=> $stable(ones_phase_r))
    else $error("all-ones pattern advanced without master clock");

  a_fall_negative: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    s_normal_fall |=> line_neg_r == ($past(sym) == ETC_SYM_NEG))
    else $error("negative pulse not captured on falling edge");

  a_ones_entry: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
    clk_en && !host_mode && tx_line_clock_lvl && !mclk_static && high_cnt_r > 5'(HIGH_MCLK_LIMIT)
    |=> tx_all_ones_mode)
    else $error("all ones not entered after long high line clock");

  a_shaper_entry: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
    s_parked_high_still |=> !shaper_en_r)
    else $error("shaper left on with both clocks static");

  a_ones_advance: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
    clk_en && tx_all_ones_mode && mclk_rise |=> $changed(ones_phase_r))
    else $error("all-ones pattern did not follow master clock");

  a_line_resume: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    s_line_resumed |=> mode_r == ETC_NORMAL)
    else $error("line clock toggling did not leave static mode");

  a_frozen_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(mode_r) && $stable(line_pos_r) && $stable(drive_oe_r))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// file: bench/etc_framer_model.sv
// framer side model: makes the line clock and the master clock
// assumes the bench sets the run and idle controls off the clk edge
`timescale 1ns/1ps
`default_nettype none
module etc_framer_model (
  input  wire logic lclk_run,
  input  wire logic lclk_idle,
  input  wire logic mclk_run,
  output logic      tx_line_clock,
  output logic      master_clock
);
  initial begin
    tx_line_clock = 1'b0;
    master_clock  = 1'b0;
  end
  // stopped line clock parks at the asked level, never floats
  always #200 tx_line_clock = lclk_run ? ~tx_line_clock : lclk_idle;
  // fixed half period keeps the master rate steady
  always #244 master_clock = mclk_run ? ~master_clock : master_clock;
endmodule
`default_nettype wire

// file: bench/e1_tx_clock_mode_detect_test.sv
// bench top: drives one channel and judges its mode and line outputs
// assumes etc_pkg and the framer model are compiled first
`timescale 1ns/1ps
`default_nettype none
module e1_tx_clock_mode_detect_test;
  import etc_pkg::*;
  logic      clk = 1'b0, reset_n = 1'b0, host_mode = 1'b0, host_all_ones = 1'b0;
  logic      lclk_run = 1'b1, lclk_idle = 1'b0, mclk_run = 1'b1, pos = 1'b0, neg = 1'b0;
  logic      clk_en = 1'b1;
  logic      tx_line_clock, master_clock, line_pos_r, line_neg_r, drive_oe_r, shaper_en_r, aom;
  etc_mode_t mode_r;
  int        n_errors = 0, checks_done = 0;
  always #25 clk = ~clk;
  etc_framer_model etc_framer_model_inst (.lclk_run(lclk_run), .lclk_idle(lclk_idle),
    .mclk_run(mclk_run), .tx_line_clock(tx_line_clock), .master_clock(master_clock));
  etc_tx_clock_mode etc_tx_clock_mode_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .host_mode(host_mode), .host_all_ones(host_all_ones), .tx_line_clock(tx_line_clock),
    .master_clock(master_clock), .tx_positive_pulse_in(pos), .tx_negative_pulse_in(neg),
    .line_pos_r(line_pos_r), .line_neg_r(line_neg_r), .drive_oe_r(drive_oe_r),
    .shaper_en_r(shaper_en_r), .tx_all_ones_mode(aom), .mode_r(mode_r));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_mode(input etc_mode_t m, input int max);
    int i;
    for (i = 0; i < max && mode_r !== m; i++) step(1);
    checks_done++;
    if (mode_r !== m) begin
      n_errors++;
      $display("wrong value at %0t: mode %0d", $time, mode_r);
      print_verdict();
    end
  endtask
  task automatic restart();
    mclk_run = 1'b1;
    lclk_run = 1'b1;
    wait_mode(ETC_NORMAL, 80);
    chk(drive_oe_r & shaper_en_r, 1'b1, "drivers back");
  endtask
  task automatic t_sample();
    logic [1:0] pat [3] = '{2'b10, 2'b01, 2'b11};
    foreach (pat[k]) begin
      {pos, neg} = pat[k];
      step(40);
      chk(line_pos_r, pat[k] == 2'b10, "pos sample");
      chk(line_neg_r, pat[k] == 2'b01, "neg sample");
    end
    $display("test sample done");
  endtask
  task automatic t_tristate();
    clk_en = 1'b0;
    lclk_run = 1'b0;
    lclk_idle = 1'b0;
    step(100);
    chk(drive_oe_r, 1'b1, "drivers frozen while enable low");
    chk(mode_r == ETC_NORMAL, 1'b1, "mode frozen while enable low");
    clk_en = 1'b1;
    wait_mode(ETC_TRISTATE, 120);
    step(1);
    chk(drive_oe_r, 1'b0, "drivers off");
    restart();
    $display("test tristate done");
  endtask
  task automatic t_all_ones();
    logic [1:0] seen = 2'b00;
    {pos, neg} = 2'b00;
    lclk_run = 1'b0;
    lclk_idle = 1'b1;
    step(150);
    chk(aom, 1'b0, "all ones too early");
    wait_mode(ETC_ALL_ONES, 250);
    chk(aom, 1'b1, "all ones flag");
    repeat (40) begin
      step(1);
      seen |= {line_pos_r, line_neg_r};
    end
    chk(seen[1] & seen[0], 1'b1, "all ones marks");
    lclk_run = 1'b1;
    wait_mode(ETC_NORMAL, 80);
    chk(aom, 1'b0, "all ones left on toggling");
    lclk_run = 1'b0;
    mclk_run = 1'b0;
    wait_mode(ETC_SHAPER_OFF, 200);
    step(1);
    chk(shaper_en_r, 1'b0, "shaper off");
    repeat (8) begin
      pos = ~pos;
      step(4);
    end
    chk(shaper_en_r, 1'b0, "shaper stays off");
    pos = 1'b0;
    restart();
    $display("test all ones done");
  endtask
  task automatic t_host();
    host_mode = 1'b1;
    host_all_ones = 1'b1;
    wait_mode(ETC_ALL_ONES, 20);
    host_all_ones = 1'b0;
    lclk_run = 1'b0;
    lclk_idle = 1'b0;
    step(100);
    chk(drive_oe_r, 1'b1, "host ignores clock");
    chk(aom, 1'b0, "host all ones released");
    lclk_run = 1'b1;
    step(20);
    host_mode = 1'b0;
    restart();
    $display("test host done");
  endtask
  initial begin
    step(5);
    reset_n = 1'b1;
    wait_mode(ETC_NORMAL, 10);
    t_sample();
    t_tristate();
    t_all_ones();
    t_host();
    print_verdict();
  end
endmodule
`default_nettype wire
